// ==== aip_regs.vh ====
// register map and reset values of the analyzer i/o port bank
`ifndef AIP_REGS_VH
`define AIP_REGS_VH
// printed indices; byte address is four times the index
`define AIP_CAL_IDX      12'h321
`define AIP_INT_IDX      12'h322
`define AIP_SPR_IDX      12'h325
`define AIP_CTL_IDX      12'h330
`define AIP_COIL_IDX     12'h331
`define AIP_STAT_IDX     12'h332
`define AIP_MASK_IDX     12'h333
// internal output port fields
`define AIP_PERIPH_RST_BIT 6
`define AIP_CTRL_RST_N_BIT 7
// alarm port fields
`define AIP_HEALTHY_BIT  4
`define AIP_LIMIT1_BIT   5
`define AIP_LIMIT2_BIT   6
`define AIP_RANGE2_BIT   7
// control register fields
`define AIP_CTL_ALT_BIT  0
`define AIP_CTL_DIAG_BIT 1
// interrupt status fields
`define AIP_EV_CAL_ENTER 0
`define AIP_EV_CAL_EXIT  1
`define AIP_EV_CAL_SEL   2
`define AIP_EV_SPARE_IN  3
// calibration and spare input ports: top bits always one
`define AIP_IN_FILL      2'h3
// reset values
`define AIP_INT_OUT_RST  8'h40
`define AIP_GEN_OUT_RST  8'h00
`define AIP_SPR_OUT_RST  8'h00
`define AIP_CTL_RST      8'h00
`define AIP_COIL_RST     4'h0
`define AIP_MASK_RST     4'h0
`endif

// ==== aip_port_bank.v ====
// analyzer i/o port bank with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`default_nettype none
`include "aip_regs.vh"

// Behaviour
// - internal input port reads at 322
// - internal output port written at 322
// - bit6 one holds serial peripherals reset
// - bit7 zero resets serial controller, low-active
// - calibration inputs at 321, bits6-7 read one
// - bit0 low requests calibration, read as-is
// - bit1 span/zero, bit2 range select
// - bit3 selects carbon dioxide or oxygen
// - spare input port at 325, bits6-7 one
// - general control output port written at 321
// - 325 output: spare bits0-3, alarms 4-7
// - bit4 healthy one, zero on alarm/diagnostics
// - bit5 one while first limit exceeded
// - bit6 one while second limit exceeded
// - bit7 one while second autorange used
// - alternate assignment: alarms follow coil values
module aip_port_bank
(
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // avalon-mm slave
   input  wire [11:0] address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   // interrupt
   output reg         irq,
   // connector inputs
   input  wire [7:0]  internal_inputs,
   input  wire        remote_calibrate_request_n,
   input  wire        remote_span_not_zero_n,
   input  wire        remote_second_range_select_n,
   input  wire        remote_carbon_gas_select_n,
   input  wire [1:0]  calibration_spare_inputs,
   input  wire [5:0]  spare_control_inputs,
   // internal outputs
   output reg  [5:0]  internal_spare_outputs,
   output reg         serial_peripheral_reset,
   output reg         serial_controller_hw_reset_n,
   // control outputs
   output reg  [7:0]  general_control_outputs,
   output reg  [3:0]  spare_control_outputs,
   // alarm relays
   output reg         healthy_alarm_output,
   output reg         first_limit_alarm_output,
   output reg         second_limit_alarm_output,
   output reg         upper_autorange_indicator
);

   // ------------------------------------------------
   // address decode
   // ------------------------------------------------
   // misaligned byte addresses match no register
   function sel;
      input [11:0] addr;
      input [11:0] idx;
      begin
         sel = (addr[1:0] == 2'h0) &&
               (addr[11:2] == idx[9:0]);
      end
   endfunction

   // ------------------------------------------------
   // state
   // ------------------------------------------------
   reg  [7:0] internal_output_port;
   reg  [7:0] alarm_and_control_outputs;
   reg  [7:0] ctl;
   reg  [3:0] coil;
   reg  [3:0] irq_status;
   reg  [3:0] irq_mask;
   reg  [5:0] cal_prev;
   reg  [5:0] spare_prev;
   reg  [3:0] next_status;
   reg  [3:0] event_set;
   reg  [31:0] next_readdata;
   reg  [3:0] next_alarms;

   wire       req;
   wire       take;
   wire [5:0] cal_now;
   wire [7:0] calibration_control_inputs;
   wire [7:0] spare_port_in;
   wire       at_cal;
   wire       at_int;
   wire       at_spr;
   wire       at_ctl;
   wire       at_coil;
   wire       at_stat;
   wire       at_mask;
   wire       wr_int;
   wire       wr_gen;
   wire       wr_spr;
   wire       wr_ctl;
   wire       wr_coil;
   wire       wr_stat;
   wire       wr_mask;

   assign req  = read | write;
   // a request completes at the edge where waitrequest is low
   assign take = req & ~waitrequest;

   // ------------------------------------------------
   // register selects and write strobes
   // ------------------------------------------------
   assign at_cal  = sel(address, `AIP_CAL_IDX);
   assign at_int  = sel(address, `AIP_INT_IDX);
   assign at_spr  = sel(address, `AIP_SPR_IDX);
   assign at_ctl  = sel(address, `AIP_CTL_IDX);
   assign at_coil = sel(address, `AIP_COIL_IDX);
   assign at_stat = sel(address, `AIP_STAT_IDX);
   assign at_mask = sel(address, `AIP_MASK_IDX);
   // a shared address strobes only its output latch, never the input
   assign wr_int  = take & write & at_int;
   assign wr_gen  = take & write & at_cal;
   assign wr_spr  = take & write & at_spr;
   assign wr_ctl  = take & write & at_ctl;
   assign wr_coil = take & write & at_coil;
   assign wr_stat = take & write & at_stat;
   assign wr_mask = take & write & at_mask;

   // ------------------------------------------------
   // input ports
   // ------------------------------------------------
   // levels are reported exactly as the remote contacts drive them
   assign cal_now = {calibration_spare_inputs,
                     remote_carbon_gas_select_n,
                     remote_second_range_select_n,
                     remote_span_not_zero_n,
                     remote_calibrate_request_n};
   assign calibration_control_inputs =
      {`AIP_IN_FILL, cal_now};
   assign spare_port_in =
      {`AIP_IN_FILL, spare_control_inputs};

   // ------------------------------------------------
   // read mux
   // ------------------------------------------------
   always @*
   begin
      // unmapped reads return zero but are still answered
      next_readdata = 32'h0000_0000;
      if (at_cal)
         next_readdata[7:0] = calibration_control_inputs;
      else if (at_int)
         next_readdata[7:0] = internal_inputs;
      else if (at_spr)
         next_readdata[7:0] = spare_port_in;
      else if (at_ctl)
         next_readdata[7:0] = ctl;
      else if (at_coil)
         next_readdata[3:0] = coil;
      else if (at_stat)
         next_readdata[3:0] = irq_status;
      else if (at_mask)
         next_readdata[3:0] = irq_mask;
   end

   // ------------------------------------------------
   // bus handshake
   // ------------------------------------------------
   // fixed two-edge answer: one wait state, then the access edge
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end
      else if (take)
      begin
         waitrequest <= 1'b1;
      end
      else if (req)
      begin
         waitrequest <= 1'b0;
         if (read)
            readdata <= next_readdata;
      end
   end

   // ------------------------------------------------
   // writable latches
   // ------------------------------------------------
   // latches hold until rewritten; reads never touch them
   always @(posedge clk_sys)
   begin
      if (rst)
         internal_output_port <= `AIP_INT_OUT_RST;
      else if (wr_int)
         internal_output_port <= writedata[7:0];
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         general_control_outputs <= `AIP_GEN_OUT_RST;
      else if (wr_gen)
         general_control_outputs <= writedata[7:0];
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         alarm_and_control_outputs <= `AIP_SPR_OUT_RST;
      else if (wr_spr)
         alarm_and_control_outputs <= writedata[7:0];
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         ctl <= `AIP_CTL_RST;
      else if (wr_ctl)
         ctl <= writedata[7:0];
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         coil <= `AIP_COIL_RST;
      else if (wr_coil)
         coil <= writedata[3:0];
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         irq_mask <= `AIP_MASK_RST;
      else if (wr_mask)
         irq_mask <= writedata[3:0];
   end

   // ------------------------------------------------
   // input events
   // ------------------------------------------------
   always @*
   begin
      event_set = 4'h0;
      event_set[`AIP_EV_CAL_ENTER] =
         cal_prev[0] & ~cal_now[0];
      event_set[`AIP_EV_CAL_EXIT] =
         ~cal_prev[0] & cal_now[0];
      event_set[`AIP_EV_CAL_SEL] =
         |(cal_prev[5:1] ^ cal_now[5:1]);
      event_set[`AIP_EV_SPARE_IN] =
         |(spare_prev ^ spare_control_inputs);
   end

   // a new event wins over a clear in the same cycle
   always @*
   begin
      next_status = irq_status;
      if (wr_stat)
         next_status = next_status & ~writedata[3:0];
      next_status = next_status | event_set;
   end

   // edge history starts at the idle-high level of open contacts
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         cal_prev   <= 6'h3f;
         spare_prev <= 6'h3f;
      end
      else
      begin
         cal_prev   <= cal_now;
         spare_prev <= spare_control_inputs;
      end
   end

   // irq is a flop so the pin never glitches while status moves
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_status <= 4'h0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_status;
         irq        <= |(next_status & irq_mask);
      end
   end

   // ------------------------------------------------
   // alarm relay selection
   // ------------------------------------------------
   // diagnostics only pulls the healthy relay while firmware owns it
   always @*
   begin
      if (ctl[`AIP_CTL_ALT_BIT])
         next_alarms = coil;
      else
      begin
         next_alarms[0] =
            alarm_and_control_outputs[`AIP_HEALTHY_BIT] &
            ~ctl[`AIP_CTL_DIAG_BIT];
         next_alarms[1] =
            alarm_and_control_outputs[`AIP_LIMIT1_BIT];
         next_alarms[2] =
            alarm_and_control_outputs[`AIP_LIMIT2_BIT];
         next_alarms[3] =
            alarm_and_control_outputs[`AIP_RANGE2_BIT];
      end
   end

   // ------------------------------------------------
   // output pins
   // ------------------------------------------------
   // pins follow the latches one edge later so each is a flop;
   // reset holds the serial controller and peripherals in reset
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         internal_spare_outputs       <= 6'h00;
         serial_peripheral_reset      <= 1'b1;
         serial_controller_hw_reset_n <= 1'b0;
      end
      else
      begin
         internal_spare_outputs <= internal_output_port[5:0];
         serial_peripheral_reset <=
            internal_output_port[`AIP_PERIPH_RST_BIT];
         serial_controller_hw_reset_n <=
            internal_output_port[`AIP_CTRL_RST_N_BIT];
      end
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         spare_control_outputs <= 4'h0;
      else
         spare_control_outputs <=
            alarm_and_control_outputs[3:0];
   end

   // ------------------------------------------------
   // alarm relay pins
   // ------------------------------------------------
   // relays stay open in reset, so no false healthy report at start
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         healthy_alarm_output         <= 1'b0;
         first_limit_alarm_output     <= 1'b0;
         second_limit_alarm_output    <= 1'b0;
         upper_autorange_indicator    <= 1'b0;
      end
      else
      begin
         healthy_alarm_output      <= next_alarms[0];
         first_limit_alarm_output  <= next_alarms[1];
         second_limit_alarm_output <= next_alarms[2];
         upper_autorange_indicator <= next_alarms[3];
      end
   end

endmodule
`default_nettype wire

// ==== aip_port_bank_sva.sv ====
// checker of the port bank bus and pin behaviour
`default_nettype none
module aip_port_bank_sva
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // bus
   input wire logic [11:0] address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        irq,
   // pins
   input wire logic [7:0]  internal_inputs,
   input wire logic [5:0]  spare_control_inputs,
   input wire logic [7:0]  general_control_outputs,
   input wire logic [3:0]  spare_control_outputs,
   input wire logic        serial_peripheral_reset,
   input wire logic        serial_controller_hw_reset_n
);
   // ----------
   // assertions
   // ----------
   wire wr_ok = write & ~waitrequest;
   wire rd_ok = read & ~waitrequest;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_reset_values:
      assert property (disable iff (1'b0) rst |=> waitrequest && !irq &&
         serial_peripheral_reset && !serial_controller_hw_reset_n)
      else $error("bad reset state");
   chk_wait_one:
      assert property (!waitrequest |=> waitrequest)
      else $error("long wait low");
   chk_gen_latch:
      assert property (wr_ok && address == 12'hc84 |=>
         general_control_outputs == $past(writedata[7:0]))
      else $error("general latch");
   chk_periph_rst:
      assert property (wr_ok && address == 12'hc88 |-> ##2
         serial_peripheral_reset == $past(writedata[6], 2))
      else $error("peripheral reset");
   chk_ctrl_rst:
      assert property (wr_ok && address == 12'hc88 |-> ##2
         serial_controller_hw_reset_n == $past(writedata[7], 2))
      else $error("controller reset");
   chk_spare_out:
      assert property (wr_ok && address == 12'hc94 |-> ##2
         spare_control_outputs == $past(writedata[3:0], 2))
      else $error("spare outputs");
   chk_int_read:
      assert property (rd_ok && address == 12'hc88 |->
         readdata == {24'h0, $past(internal_inputs)})
      else $error("internal read");
   chk_spare_read:
      assert property (rd_ok && address == 12'hc94 |->
         readdata == {24'h0, 2'h3, $past(spare_control_inputs)})
      else $error("spare read");
   cov_alarm_wr: cover property (wr_ok && address == 12'hc94);
   cov_cal_rd: cover property (rd_ok && address == 12'hc84);
   cov_irq: cover property ($rose(irq));
endmodule
bind aip_port_bank aip_port_bank_sva chk_u (.*);
`default_nettype wire

// ==== aip_cal_contacts.sv ====
// model of the remote calibration contact closures
`default_nettype none
module aip_cal_contacts
#(
   parameter int SETTLE = 3
)
(
   // clock and wanted contact levels
   input  wire logic       clk_sys,
   input  wire logic [5:0] level,
   // contact lines, pulled up when open
   output wire logic       remote_calibrate_request_n,
   output wire logic       remote_span_not_zero_n,
   output wire logic       remote_second_range_select_n,
   output wire logic       remote_carbon_gas_select_n,
   output wire logic [1:0] calibration_spare_inputs
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------
   // contact closure
   // ---------------
   logic [5:0] pins = 6'h3f;
   int         cnt = 0;
   // relay contacts settle slowly, so a new level lands late
   always @(posedge clk_sys)
   begin
      if (level == pins)
         cnt <= 0;
      else if (cnt < SETTLE)
         cnt <= cnt + 1;
      else
         pins <= level;
   end
   assign {calibration_spare_inputs, remote_carbon_gas_select_n,
      remote_second_range_select_n, remote_span_not_zero_n,
      remote_calibrate_request_n} = pins;
endmodule
`default_nettype wire

// ==== aip_port_bank_tb.sv ====
// self-checking bench of the analyzer port bank
`default_nettype none
module aip_port_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // signals and tasks
   // ----------------
   logic        clk_sys = 0, rst = 1, read = 0, write = 0;
   logic [11:0] address = 12'h0;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic [7:0]  internal_inputs = 8'h96, general_control_outputs, d;
   logic [5:0]  level = 6'h35, spare_control_inputs = 6'h29;
   logic [5:0]  internal_spare_outputs;
   logic [3:0]  spare_control_outputs;
   logic [1:0]  calibration_spare_inputs;
   logic        waitrequest, irq, serial_peripheral_reset;
   logic        serial_controller_hw_reset_n, remote_calibrate_request_n;
   logic        remote_span_not_zero_n, remote_second_range_select_n;
   logic        remote_carbon_gas_select_n, healthy_alarm_output;
   logic        first_limit_alarm_output, second_limit_alarm_output;
   logic        upper_autorange_indicator;
   int          num_errors = 0, samples_checked = 0, i;
   wire  [3:0]  alarms = {upper_autorange_indicator,
      second_limit_alarm_output, first_limit_alarm_output,
      healthy_alarm_output};
   wire  [7:0]  int_pins = {serial_controller_hw_reset_n,
      serial_peripheral_reset, internal_spare_outputs};

   aip_port_bank dut_u (.*);
   aip_cal_contacts #(.SETTLE(3)) cal_u (.*);
   always #5 clk_sys = ~clk_sys;

   task automatic results();
      if (num_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
         num_errors++;
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // one avalon access; request held until waitrequest is seen low
   task automatic acc(input logic wr, input logic [11:0] a,
      input logic [31:0] dv);
      int n;
      @(posedge clk_sys);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= dv;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 100);
      if (waitrequest !== 1'b0)
      begin
         num_errors++;
         results();
      end
      else
      begin
         q = readdata;
         read <= 0;
         write <= 0;
      end
   endtask

   initial
   begin
      tick(6);
      rst <= 0;
      chk(int_pins[7:6], 2'h1);
      for (i = 0; i < 4; i++)
      begin
         d = {i[1:0], 6'h15 + i[5:0]};
         acc(1, 12'hc88, {24'h0, d});
         tick(2);
         chk(int_pins, d);
      end
      acc(0, 12'hc88, 0);
      chk(q, 32'h96);
      acc(0, 12'hc94, 0);
      chk(q, 32'he9);
      acc(1, 12'hc84, 32'ha5);
      tick(1);
      chk(general_control_outputs, 8'ha5);
      for (i = 0; i < 64; i += 13)
      begin
         level <= i[5:0];
         tick(6);
         acc(0, 12'hc84, 0);
         chk(q, {24'h0, 2'h3, i[5:0]});
      end
      for (i = 0; i < 3; i++)
      begin
         d = 8'h5a + i[7:0] * 8'h4d;
         acc(1, 12'hc94, {24'h0, d});
         tick(2);
         chk({alarms, spare_control_outputs}, d);
      end
      acc(1, 12'hcc0, 32'h2);
      tick(2);
      chk(alarms, 4'he);
      acc(1, 12'hcc4, 32'h6);
      acc(1, 12'hcc0, 32'h3);
      tick(2);
      chk(alarms, 4'h6);
      acc(0, 12'hff0, 0);
      chk(q, 32'h0);
      level <= 6'h35;
      tick(6);
      acc(1, 12'hcc8, 32'hf);
      acc(1, 12'hccc, 32'h1);
      tick(2);
      chk(irq, 1'h0);
      level <= 6'h34;
      tick(8);
      chk(irq, 1'h1);
      acc(1, 12'hccc, 32'h0);
      tick(2);
      chk(irq, 1'h0);
      acc(1, 12'hccc, 32'h1);
      acc(0, 12'hcc8, 0);
      chk(q[0], 1'h1);
      acc(1, 12'hcc8, 32'h1);
      tick(2);
      chk(irq, 1'h0);
      results();
   end
endmodule
`default_nettype wire
